// [include/status_out_defs.svh]
/*
  Constants for the servo status output logic: timing, ranges and defaults.
  Assumes inclusion by its bare name from the design file.
*/
`ifndef STATUS_OUT_DEFS_SVH
`define STATUS_OUT_DEFS_SVH

// Clock and millisecond tick
`define SYS_CLK_HZ          25000000
`define TICK_PERIOD_MS      1
`define TICK_CYCLES         ((`SYS_CLK_HZ / 1000) * `TICK_PERIOD_MS)

// Completion condition select codes
`define COND_RANGE_ONLY     2'h0
`define COND_NO_CMD         2'h1
`define COND_ZERO_SPEED     2'h2
`define COND_HOLD           2'h3

// Speed detection
`define SPEED_HYST_RPM      16'h000a
`define ZERO_SPEED_DEFAULT  16'h0032
`define ARRIVAL_DEFAULT     16'h03e8

// Position ranges and limits
`define RANGE_B_DEFAULT     19'h0000a
`define HOLD_TIME_MAX_MS    15'h7530
`define BRAKE_DELAY_MAX_MS  14'h2710

// Warning selector
`define WARN_SEL_ANY        4'h0
`define WARN_SRC_COUNT      13

`endif

// [include/status_out_pkg.sv]
/*
  Types for the servo status output logic.
  Assumes the defs header sits on the include path.
*/
package status_out_pkg;
  // Brake interlock sequence states
  typedef enum logic [3:0] {
    BRK_RUN      = 4'b0001,
    BRK_STOP_DLY = 4'b0010,
    BRK_DECEL    = 4'b0100,
    BRK_OFF      = 4'b1000
  } brake_state_e;
endpackage : status_out_pkg

// [rtl/servo_status_output_logic.sv]
/*
  Status outputs of a servo drive: completion outputs, speed detection,
  brake interlock sequencing and selectable warning outputs.
  Assumes all inputs except run_cmd_i come from logic on sys_clk_i;
  run_cmd_i arrives from the host and is synchronised here.
*/
// Overview of operation
// - Select 0: done A on error in range A; select 1 also needs no command.
// - Select 2: done A needs zero speed, error in range A, no command.
// - Select 3: done A latched for hold time, then follows position error.
// - Hold time 0 to 30000 ms, used only with select 3.
// - Hold time zero holds done A until next position command.
// - Position command during hold drops done A at once.
// - Zero speed asserts below threshold 10 to 20000 r/min, default 50.
// - Zero speed uses speed magnitude with 10 r/min hysteresis.
// - Speed reached asserts at arrival speed, default 1000, 10 r/min hysteresis.
// - Run drop while stopped: brake first, power off after stopped delay.
// - Run drop while moving: brake after running delay or below release speed.
// - Warning output A selector 0 to 13: 0 any warning, else one source.
// - Warning output B has its own selector, same encoding.
// - Done B asserts when error below range B, ignoring command and select.
// - Range B in command units, encoder units under unit select.
// - Ranges compare absolute position error, during position control only.
`timescale 1ns/1ns
`include "status_out_defs.svh"

module servo_status_output_logic #(
  parameter int ERR_W  = 32,
  parameter int TICK_N = `TICK_CYCLES
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic signed [ERR_W-1:0] pos_err_cmd_i,
  input  wire logic signed [ERR_W-1:0] pos_err_enc_i,
  input  wire logic              position_ctrl_i,
  input  wire logic              pos_cmd_active_i,
  input  wire logic signed [15:0] motor_speed_i,
  input  wire logic              run_cmd_i,
  input  wire logic [12:0]       warn_src_i,
  input  wire logic [18:0]       done_range_a_i,
  input  wire logic [18:0]       done_range_b_i,
  input  wire logic [1:0]        done_condition_sel_i,
  input  wire logic [14:0]       done_hold_time_i,
  input  wire logic              position_unit_sel_i,
  input  wire logic [15:0]       zero_speed_threshold_i,
  input  wire logic [15:0]       arrival_speed_threshold_i,
  input  wire logic [13:0]       brake_delay_stopped_i,
  input  wire logic [13:0]       brake_delay_running_i,
  input  wire logic [15:0]       brake_release_speed_i,
  input  wire logic [3:0]        warn_out_a_sel_i,
  input  wire logic [3:0]        warn_out_b_sel_i,
  output logic                   pos_done_out_a_o,
  output logic                   pos_done_out_b_o,
  output logic                   zero_speed_out_o,
  output logic                   speed_reached_out_o,
  output logic                   brake_hold_out_o,
  output logic                   servo_power_o,
  output logic                   decel_req_o,
  output logic                   warn_out_a_o,
  output logic                   warn_out_b_o,
  output status_out_pkg::brake_state_e brake_state_o
);
  import status_out_pkg::*;

  function automatic logic [ERR_W-1:0] abs_err(input logic signed [ERR_W-1:0] v);
    abs_err = v[ERR_W-1] ? ERR_W'(-v) : ERR_W'(v);
  endfunction : abs_err

  function automatic logic warn_pick(input logic [3:0] sel, input logic [12:0] src);
    if (sel == `WARN_SEL_ANY) begin
      warn_pick = |src;
    end else if (sel <= 4'(`WARN_SRC_COUNT)) begin
      warn_pick = src[sel - 4'h1];
    end else begin
      warn_pick = 1'b0;
    end
  endfunction : warn_pick

  //////////////////////////////////////////////////////////////////////////////
  // Tick, sync, magnitudes
  logic [15:0] tick_cnt_q;
  logic        tick;
  logic        run_meta_q;
  logic        run_sync_q;
  logic [15:0] speed_mag;
  logic [ERR_W-1:0] err_a_mag;
  logic [ERR_W-1:0] err_b_mag;
  logic        in_range_a;

  // One millisecond tick
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || tick) begin
      tick_cnt_q <= 16'h0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end
  assign tick = (tick_cnt_q == 16'(TICK_N - 1));

  // Two-stage sync of run command
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      run_meta_q <= 1'b0;
      run_sync_q <= 1'b0;
    end else begin
      run_meta_q <= run_cmd_i;
      run_sync_q <= run_meta_q;
    end
  end

  // Speed and error magnitudes
  assign speed_mag  = motor_speed_i[15] ? 16'(-motor_speed_i) : 16'(motor_speed_i);
  assign err_a_mag  = abs_err(pos_err_cmd_i);
  assign err_b_mag  = position_unit_sel_i ? abs_err(pos_err_enc_i) : err_a_mag;
  assign in_range_a = position_ctrl_i && (err_a_mag <= ERR_W'(done_range_a_i));

  //////////////////////////////////////////////////////////////////////////////
  // Speed detection with hysteresis
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      zero_speed_out_o <= 1'b0;
    end else if (speed_mag < zero_speed_threshold_i) begin
      zero_speed_out_o <= 1'b1;
    end else if (speed_mag >= zero_speed_threshold_i + `SPEED_HYST_RPM) begin
      zero_speed_out_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      speed_reached_out_o <= 1'b0;
    end else if (speed_mag >= arrival_speed_threshold_i) begin
      speed_reached_out_o <= 1'b1;
    end else if (speed_mag + `SPEED_HYST_RPM < arrival_speed_threshold_i) begin
      speed_reached_out_o <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Completion output A with hold timer
  logic        holding_q;
  logic [14:0] hold_cnt_q;
  logic        hold_expired;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      holding_q  <= 1'b0;
      hold_cnt_q <= 15'h0000;
    end else if (done_condition_sel_i != `COND_HOLD || pos_cmd_active_i) begin
      holding_q  <= 1'b0;
      hold_cnt_q <= 15'h0000;
    end else if (!holding_q && in_range_a) begin
      holding_q  <= 1'b1;
      hold_cnt_q <= 15'h0000;
    end else if (holding_q && !hold_expired && tick) begin
      hold_cnt_q <= hold_cnt_q + 15'h0001;
    end
  end

  // Count stops at a nonzero hold time, so it never wraps into a new hold
  assign hold_expired = (done_hold_time_i != 15'h0000) && (hold_cnt_q >= done_hold_time_i);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pos_done_out_a_o <= 1'b0;
    end else begin
      case (done_condition_sel_i)
        `COND_RANGE_ONLY: pos_done_out_a_o <= in_range_a;
        `COND_NO_CMD:     pos_done_out_a_o <= in_range_a && !pos_cmd_active_i;
        `COND_ZERO_SPEED: pos_done_out_a_o <= in_range_a && !pos_cmd_active_i
                                              && zero_speed_out_o;
        `COND_HOLD: begin
          if (pos_cmd_active_i) begin
            pos_done_out_a_o <= 1'b0;
          end else if (holding_q && !hold_expired) begin
            pos_done_out_a_o <= 1'b1;
          end else begin
            pos_done_out_a_o <= in_range_a;
          end
        end
        default: pos_done_out_a_o <= 1'b0;
      endcase
    end
  end

  // Completion output B
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pos_done_out_b_o <= 1'b0;
    end else begin
      pos_done_out_b_o <= position_ctrl_i && (err_b_mag < ERR_W'(done_range_b_i));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Brake interlock sequence
  brake_state_e brk_q;
  logic [13:0]  brk_cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      brk_q     <= BRK_OFF;
      brk_cnt_q <= 14'h0000;
    end else begin
      case (brk_q)
        BRK_RUN: begin
          brk_cnt_q <= 14'h0000;
          if (!run_sync_q) begin
            brk_q <= zero_speed_out_o ? BRK_STOP_DLY : BRK_DECEL;
          end
        end
        BRK_STOP_DLY: begin
          if (brk_cnt_q >= brake_delay_stopped_i) begin
            brk_q <= BRK_OFF;
          end else if (tick) begin
            brk_cnt_q <= brk_cnt_q + 14'h0001;
          end
        end
        BRK_DECEL: begin
          if (brk_cnt_q >= brake_delay_running_i || speed_mag < brake_release_speed_i) begin
            brk_q <= BRK_OFF;
          end else if (tick) begin
            brk_cnt_q <= brk_cnt_q + 14'h0001;
          end
        end
        BRK_OFF: begin
          brk_cnt_q <= 14'h0000;
          if (run_sync_q) begin
            brk_q <= BRK_RUN;
          end
        end
        default: brk_q <= BRK_OFF;
      endcase
    end
  end

  // Brake and power outputs follow the state
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      brake_hold_out_o <= 1'b1;
      servo_power_o    <= 1'b0;
      decel_req_o      <= 1'b0;
    end else begin
      brake_hold_out_o <= (brk_q == BRK_STOP_DLY) || (brk_q == BRK_OFF);
      servo_power_o    <= (brk_q != BRK_OFF);
      decel_req_o      <= (brk_q == BRK_DECEL);
    end
  end
  assign brake_state_o = brk_q;
  //////////////////////////////////////////////////////////////////////////////
  // Warning outputs
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      warn_out_a_o <= 1'b0;
      warn_out_b_o <= 1'b0;
    end else begin
      warn_out_a_o <= warn_pick(warn_out_a_sel_i, warn_src_i);
      warn_out_b_o <= warn_pick(warn_out_b_sel_i, warn_src_i);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_run_drop_stopped;
    (brk_q == BRK_RUN) && !run_sync_q && zero_speed_out_o;
  endsequence
  AST_TICK_PERIOD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    tick |=> !tick [*2]) else $error("tick too frequent");
  AST_STOP_BRAKE_FIRST: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_run_drop_stopped |=> (brk_q == BRK_STOP_DLY) ##1 (brake_hold_out_o && servo_power_o))
    else $error("brake not engaged before power off");
  AST_DECEL_ENTRY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (brk_q == BRK_RUN) && !run_sync_q && !zero_speed_out_o |=> brk_q == BRK_DECEL)
    else $error("running drop did not decelerate");
  AST_RELEASE_SPEED: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (brk_q == BRK_DECEL) && speed_mag < brake_release_speed_i |=> ##1 brake_hold_out_o)
    else $error("brake late below release speed");
  AST_CMD_DROPS_A: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    pos_cmd_active_i && done_condition_sel_i != `COND_RANGE_ONLY |=> !pos_done_out_a_o)
    else $error("done A high during command");
  AST_SEL0_FOLLOW: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    done_condition_sel_i == `COND_RANGE_ONLY |=> pos_done_out_a_o == $past(in_range_a))
    else $error("done A wrong for select 0");
  AST_SEL2_ZERO: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    done_condition_sel_i == `COND_ZERO_SPEED && !zero_speed_out_o |=> !pos_done_out_a_o)
    else $error("done A without zero speed");
  AST_ZERO_SPEED_SET: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    speed_mag < zero_speed_threshold_i |=> zero_speed_out_o)
    else $error("zero speed missed");
  AST_ZERO_SPEED_HYST: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    zero_speed_out_o && speed_mag < zero_speed_threshold_i + `SPEED_HYST_RPM
    |=> zero_speed_out_o) else $error("zero speed hysteresis broken");
  AST_DONE_B: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    position_ctrl_i && err_b_mag < ERR_W'(done_range_b_i) |=> pos_done_out_b_o)
    else $error("done B missed");
  AST_WARN_ANY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    warn_out_a_sel_i == `WARN_SEL_ANY && |warn_src_i |=> warn_out_a_o)
    else $error("warning A missed");
endmodule : servo_status_output_logic

// [sim/host_model.sv]
/*
  Host controller model: drives the operation command toward the drive.
  Assumes the drive synchronises run_cmd_o itself.
*/
`timescale 1ns/1ns

module host_model (
  input  wire logic sys_clk_i,
  output logic      run_cmd_o
);
  initial run_cmd_o = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Operation command change, just after a clock edge
  task automatic set_run(input logic v);
    @(posedge sys_clk_i);
    #1 run_cmd_o = v;
  endtask : set_run
endmodule : host_model

// [sim/tb_top.sv]
/*
  Self-checking bench for the servo status output logic.
  Assumes a 1 ms tick of 4 clock cycles through TICK_N.
*/
`timescale 1ns/1ns
`define CHECK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end

module tb_top;
  import status_out_pkg::*;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, run_cmd_i;
  logic signed [31:0] pos_err_cmd_i = 0, pos_err_enc_i = 0;
  logic position_ctrl_i = 1'b1, pos_cmd_active_i = 1'b0, position_unit_sel_i = 1'b0;
  logic signed [15:0] motor_speed_i = 0;
  logic [12:0] warn_src_i = 13'h0000;
  logic [18:0] done_range_a_i = 19'h00064, done_range_b_i = 19'h0000a;
  logic [1:0] done_condition_sel_i = 2'h0;
  logic [14:0] done_hold_time_i = 15'h0002;
  logic [15:0] zero_speed_threshold_i = 16'h0032, arrival_speed_threshold_i = 16'h03e8;
  logic [13:0] brake_delay_stopped_i = 14'h0003, brake_delay_running_i = 14'h0005;
  logic [15:0] brake_release_speed_i = 16'h0064;
  logic [3:0] warn_out_a_sel_i = 4'h0, warn_out_b_sel_i = 4'h0;
  logic pos_done_out_a_o, pos_done_out_b_o, zero_speed_out_o, speed_reached_out_o;
  logic brake_hold_out_o, servo_power_o, decel_req_o, warn_out_a_o, warn_out_b_o;
  brake_state_e brake_state_o;
  int n_mismatch = 0, checked = 0, cycles = 0, n;

  servo_status_output_logic #(.ERR_W(32), .TICK_N(4)) u_servo_status_output_logic (
    .sys_clk_i, .reset_i, .pos_err_cmd_i, .pos_err_enc_i, .position_ctrl_i,
    .pos_cmd_active_i, .motor_speed_i, .run_cmd_i, .warn_src_i, .done_range_a_i,
    .done_range_b_i, .done_condition_sel_i, .done_hold_time_i, .position_unit_sel_i,
    .zero_speed_threshold_i, .arrival_speed_threshold_i, .brake_delay_stopped_i,
    .brake_delay_running_i, .brake_release_speed_i, .warn_out_a_sel_i,
    .warn_out_b_sel_i, .pos_done_out_a_o, .pos_done_out_b_o, .zero_speed_out_o,
    .speed_reached_out_o, .brake_hold_out_o, .servo_power_o, .decel_req_o,
    .warn_out_a_o, .warn_out_b_o, .brake_state_o);
  host_model u_host_model (.sys_clk_i(sys_clk_i), .run_cmd_o(run_cmd_i));

  // Clock and cycle ceiling
  always #20 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : step

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Completion outputs under selects 0 to 2 and range B
  task automatic test_done_basic();
    pos_err_cmd_i = 100; step(2);
    `CHECK(pos_done_out_a_o, 1'b1)
    pos_err_cmd_i = -101; step(2);
    `CHECK(pos_done_out_a_o, 1'b0)
    done_range_a_i = 19'h00065; step(2);
    `CHECK(pos_done_out_a_o, 1'b1)
    done_range_a_i = 19'h00064; pos_err_cmd_i = 50; pos_cmd_active_i = 1'b1; step(2);
    `CHECK(pos_done_out_a_o, 1'b1)
    done_condition_sel_i = 2'h1; step(2);
    `CHECK(pos_done_out_a_o, 1'b0)
    done_condition_sel_i = 2'h2; pos_cmd_active_i = 1'b0; step(3);
    `CHECK(pos_done_out_a_o, 1'b1)
    motor_speed_i = 500; step(3);
    `CHECK(pos_done_out_a_o, 1'b0)
    motor_speed_i = 0; pos_err_cmd_i = -10; pos_err_enc_i = 9; step(2);
    `CHECK(pos_done_out_b_o, 1'b0)
    pos_err_cmd_i = -9; pos_err_enc_i = 10; pos_cmd_active_i = 1'b1; step(2);
    `CHECK(pos_done_out_b_o, 1'b1)
    position_unit_sel_i = 1'b1; step(2);
    `CHECK(pos_done_out_b_o, 1'b0)
    pos_err_enc_i = -9; position_ctrl_i = 1'b0; step(2);
    `CHECK(pos_done_out_b_o, 1'b0)
    position_ctrl_i = 1'b1; step(2);
    `CHECK(pos_done_out_b_o, 1'b1)
    done_range_b_i = 19'h00009; step(2);
    `CHECK(pos_done_out_b_o, 1'b0)
    done_range_b_i = 19'h0000a;
  endtask : test_done_basic

  // Select 3 hold, expiry, command abort and unbounded hold
  task automatic test_done_hold();
    done_condition_sel_i = 2'h3; pos_cmd_active_i = 1'b0; pos_err_cmd_i = 0; step(2);
    `CHECK(pos_done_out_a_o, 1'b1)
    pos_err_cmd_i = 500; step(3);
    `CHECK(pos_done_out_a_o, 1'b1)
    for (n = 0; n < 30 && pos_done_out_a_o === 1'b1; n++) step(1);
    `CHECK(pos_done_out_a_o, 1'b0)
    `CHECK(n >= 2 && n <= 12, 1'b1)
    pos_cmd_active_i = 1'b1; step(2);
    pos_cmd_active_i = 1'b0; pos_err_cmd_i = 0; step(2);
    pos_err_cmd_i = 500; pos_cmd_active_i = 1'b1; step(2);
    `CHECK(pos_done_out_a_o, 1'b0)
    done_hold_time_i = 15'h0000; pos_cmd_active_i = 1'b0; pos_err_cmd_i = 0; step(2);
    pos_err_cmd_i = 500; step(40);
    `CHECK(pos_done_out_a_o, 1'b1)
    pos_cmd_active_i = 1'b1; step(2);
    `CHECK(pos_done_out_a_o, 1'b0)
  endtask : test_done_hold

  // Speed detection thresholds with hysteresis
  task automatic test_speed();
    logic signed [15:0] spd [8] = '{55, -60, 55, -49, 1000, -995, 989, 995};
    logic exp_zs [8] = '{1, 0, 0, 1, 0, 0, 0, 0};
    logic exp_sr [8] = '{0, 0, 0, 0, 1, 1, 0, 0};
    for (int i = 0; i < 8; i++) begin
      motor_speed_i = spd[i]; step(2);
      `CHECK(zero_speed_out_o, exp_zs[i])
      `CHECK(speed_reached_out_o, exp_sr[i])
    end
    zero_speed_threshold_i = 16'h03e8; arrival_speed_threshold_i = 16'h03e0; step(2);
    `CHECK(zero_speed_out_o, 1'b1)
    `CHECK(speed_reached_out_o, 1'b1)
    zero_speed_threshold_i = 16'h0032; arrival_speed_threshold_i = 16'h03e8;
  endtask : test_speed

  // Warning selector A over all codes, selector B over codes 1 to 13
  task automatic test_warn();
    for (int s = 0; s < 16; s++) begin
      warn_out_a_sel_i = 4'(s); warn_out_b_sel_i = 4'((s % 13) + 1);
      warn_src_i = (s == 0) ? 13'h0010 : 13'(1 << (s - 1)); step(2);
      `CHECK(warn_out_a_o, s < 14)
      `CHECK(warn_out_b_o, s == 0 && warn_out_b_sel_i == 4'h5)
      warn_src_i = ~warn_src_i; step(2);
      `CHECK(warn_out_a_o, s == 0)
      `CHECK(warn_out_b_o, 1'b1)
    end
  endtask : test_warn

  // Brake sequences on run drop, stopped and moving
  task automatic test_brake();
    motor_speed_i = 0; u_host_model.set_run(1'b1); step(8);
    `CHECK({servo_power_o, brake_hold_out_o}, 2'b10)
    u_host_model.set_run(1'b0); step(6);
    `CHECK({servo_power_o, brake_hold_out_o}, 2'b11)
    for (n = 0; n < 30 && servo_power_o === 1'b1; n++) step(1);
    `CHECK(servo_power_o, 1'b0)
    `CHECK(n >= 2, 1'b1)
    u_host_model.set_run(1'b1); motor_speed_i = 2000; step(8);
    u_host_model.set_run(1'b0); step(6);
    `CHECK({decel_req_o, brake_hold_out_o}, 2'b10)
    brake_release_speed_i = 16'h0028; motor_speed_i = 50; step(3);
    `CHECK({decel_req_o, brake_hold_out_o}, 2'b10)
    brake_release_speed_i = 16'h0064; step(3);
    `CHECK({brake_hold_out_o, servo_power_o}, 2'b10)
    `CHECK(brake_state_o, BRK_OFF)
    u_host_model.set_run(1'b1); motor_speed_i = 2000; brake_delay_running_i = 14'h0001;
    step(8);
    u_host_model.set_run(1'b0);
    for (n = 0; n < 20 && brake_hold_out_o !== 1'b1; n++) step(1);
    `CHECK({brake_hold_out_o, servo_power_o}, 2'b10)
  endtask : test_brake

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    step(5);
    `CHECK({brake_hold_out_o, servo_power_o, pos_done_out_a_o}, 3'b100)
    `CHECK(brake_state_o, BRK_OFF)
    reset_i = 1'b0;
    test_done_basic();
    test_done_hold();
    test_speed();
    test_warn();
    test_brake();
    end_of_test();
  end
endmodule : tb_top
